// File: logic/scp_dev.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
// Operation
// - 3-wire write: flag 0, address, 16 data
// - 3-wire read: device drives sixteen data bits
// - address 0 reads back part identifier
// - address 1 reads revision in bits 2:0
// - 2-wire device is target only
// - data fall with clock high starts
// - shift address and flag, MSB first
// - own address acknowledged by pulling low
// - mismatch or read flag returns idle
// - first byte register address, acknowledged
// - second byte data high, acknowledged
// - third byte data low, acknowledged
// - data rise with clock high stops
// - idle after write sequence with auto-increment off, else waits for next data pair
// - stray start or stop aborts transfer
// - fixed bus address 0011010
// - write to address 0 resets registers
// - power-on reset loads register defaults
// - clock rise samples, select rise commits
// - 24-bit word, address then 16 data
// - select pin low is 2-wire, gpio forces 3
// - auto-increment by register 9 bit 1
module scp_dev #(
  parameter int          REG_COUNT = 16,
  parameter logic [15:0] PART_ID   = 16'h5A5A, // arbitrary value
  parameter logic [2:0]  REVISION  = 3'h1      // arbitrary value
) (
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   clk_en,
  scp_link_if.device  link,
  output wire logic   wr_pulse_q,
  output wire logic [6:0]  wr_addr_q,
  output wire logic [15:0] wr_data_q,
  output wire logic   three_wire_q,
  output wire logic   write_auto_increment_q
);

  // ----------------------------------------------------------------
  // types and helpers
  // ----------------------------------------------------------------
  typedef logic [REG_COUNT-1:0][15:0] scp_bank_t;
  typedef enum logic [1:0] {TW_IDLE, TW_BITS, TW_ACK} scp_tw_e;
  typedef struct packed {
    logic [3:0]  s1;
    logic [3:0]  s2;
    logic [3:0]  s3;
    logic [3:0]  f;
    logic [3:0]  fp;
    scp_bank_t   regs;
    scp_tw_e     tw;
    logic [1:0]  idx;
    logic        done;
    logic [5:0]  cnt;
    logic [23:0] sh;
    logic [7:0]  hi;
    logic [6:0]  ptr;
    logic        rdg;
    logic [15:0] rd;
    logic        sd_o;
    logic        sd_oe_n;
    logic        three;
    logic        wr;
    logic [6:0]  wa;
    logic [15:0] wv;
  } scp_dev_st_s;

  // register defaults after power-on or soft reset
  function automatic scp_bank_t reg_defaults();
    scp_bank_t r;
    r = '0;
    r[scp_pkg::REG_CIF] = scp_pkg::REG_CIF_RESET;
    return r;
  endfunction : reg_defaults

  localparam scp_bank_t REG_DEF = reg_defaults();

  // readback value of one register address
  function automatic logic [15:0] rd_val(input logic [6:0] a,
                                         input scp_bank_t  r);
    if (a == scp_pkg::REG_SOFT_RESET) begin
      return PART_ID;
    end else if (a == scp_pkg::REG_REVISION) begin
      return {13'h0000, REVISION};
    end else if (int'(a) < REG_COUNT) begin
      return r[a];
    end
    return 16'h0000;
  endfunction : rd_val

  scp_dev_st_s q;
  scp_dev_st_s d;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0]  rise;
    logic [3:0]  fall;
    logic        bit_in;
    logic        wen;
    logic [6:0]  wa;
    logic [15:0] wv;
    logic [7:0]  b;
    rise   = q.f & ~q.fp;
    fall   = ~q.f & q.fp;
    bit_in = q.f[scp_pkg::PIN_SD];
    wen    = 1'b0;
    wa     = 7'h00;
    wv     = 16'h0000;
    b      = {q.sh[6:0], bit_in};
    d      = q;
    d.wr   = 1'b0;
    // three-stage sync, level taken once stages two and three agree
    d.s1 = {link.interface_select, link.chip_select_line,
            link.serial_data_line, link.serial_clock};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.f  = (q.s2 & q.s3) | (q.f & (q.s2 ^ q.s3));
    d.fp = q.f;
    // mode pin low selects 2-wire unless gpio override is set
    d.three = q.f[scp_pkg::PIN_MODE]
            | q.regs[scp_pkg::REG_GPIO][scp_pkg::MODE_GPIO_BIT];
    if (q.three) begin
      d.tw = TW_IDLE;
      if (fall[scp_pkg::PIN_CS]) begin
        d.cnt = 6'h00;
        d.rdg = 1'b0;
      end
      // shift one bit per clock rise inside the frame until readback starts
      if (!q.f[scp_pkg::PIN_CS] && rise[scp_pkg::PIN_SCLK] && !q.rdg) begin
        d.sh = {q.sh[22:0], bit_in};
        if (q.cnt != 6'h3F) begin
          d.cnt = q.cnt + 6'h01;
        end
        if (int'(q.cnt) == scp_pkg::RD_HDR_BITS - 1 && q.sh[6]) begin
          d.rdg = 1'b1;
          d.rd  = rd_val(b[6:0], q.regs);
        end
      end
      // readback data changes on clock fall
      if (q.rdg && !q.f[scp_pkg::PIN_CS] && fall[scp_pkg::PIN_SCLK]) begin
        d.sd_oe_n = 1'b0;
        d.sd_o    = q.rd[15];
        d.rd      = {q.rd[14:0], 1'b0};
      end
      // select rise commits the last full word
      if (rise[scp_pkg::PIN_CS]) begin
        d.sd_oe_n = 1'b1;
        d.rdg     = 1'b0;
        if (!q.rdg && int'(q.cnt) >= scp_pkg::WORD_BITS &&
            !q.sh[scp_pkg::WORD_RW_BIT]) begin
          wen = 1'b1;
          wa  = q.sh[scp_pkg::WORD_ADDR_MSB:scp_pkg::WORD_ADDR_LSB];
          wv  = q.sh[15:0];
        end
      end
    end else begin
      // target only: the clock is never driven here
      if (fall[scp_pkg::PIN_SD] && q.f[scp_pkg::PIN_SCLK]) begin
        d.tw      = TW_BITS;
        d.idx     = 2'd0;
        d.cnt     = 6'h00;
        d.done    = 1'b0;
        d.sd_oe_n = 1'b1;
      end else if (rise[scp_pkg::PIN_SD] && q.f[scp_pkg::PIN_SCLK]) begin
        d.tw      = TW_IDLE;
        d.sd_oe_n = 1'b1;
      end else begin
        unique case (q.tw)
          TW_IDLE: begin
            d.sd_oe_n = 1'b1;
          end
          TW_BITS: begin
            if (rise[scp_pkg::PIN_SCLK]) begin
              d.sh  = {q.sh[22:0], bit_in};
              d.cnt = q.cnt + 6'h01;
              if (q.cnt == 6'h07) begin
                d.cnt = 6'h00;
                d.tw  = TW_ACK;
                d.idx = q.idx + 2'd1;
                unique case (q.idx)
                  2'd0: begin
                    if (b[7:1] != scp_pkg::DEV_BUS_ADDR || b[0]) begin
                      d.tw = TW_IDLE;
                    end
                  end
                  2'd1: d.ptr = b[6:0];
                  2'd2: d.hi  = b;
                  2'd3: begin
                    wen = 1'b1;
                    wa  = q.ptr;
                    wv  = {q.hi, b};
                    if (q.regs[scp_pkg::REG_CIF][scp_pkg::WRITE_AUTO_INCREMENT_BIT]) begin
                      d.idx = 2'd2;
                      d.ptr = q.ptr + 7'h01;
                    end else begin
                      d.done = 1'b1;
                    end
                  end
                endcase
              end
            end
          end
          TW_ACK: begin
            if (fall[scp_pkg::PIN_SCLK]) begin
              if (q.sd_oe_n) begin
                d.sd_oe_n = 1'b0;
                d.sd_o    = 1'b0;
              end else begin
                d.sd_oe_n = 1'b1;
                d.tw      = q.done ? TW_IDLE : TW_BITS;
              end
            end
          end
          default: d.tw = TW_IDLE;
        endcase
      end
    end
    // register write, address 0 restores defaults
    if (wen) begin
      d.wr = 1'b1;
      d.wa = wa;
      d.wv = wv;
      if (wa == scp_pkg::REG_SOFT_RESET) begin
        d.regs = REG_DEF;
      end else if (int'(wa) < REG_COUNT) begin
        d.regs[wa] = wv;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q         <= '0;
      q.s1      <= '1;
      q.s2      <= '1;
      q.s3      <= '1;
      q.f       <= '1;
      q.fp      <= '1;
      q.regs    <= REG_DEF;
      q.sd_oe_n <= 1'b1;
      q.sd_o    <= 1'b1;
      q.three   <= 1'b1;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // outputs straight from state
  assign link.dev_sd_o    = q.sd_o;
  assign link.dev_sd_oe_n = q.sd_oe_n;
  assign wr_pulse_q       = q.wr;
  assign wr_addr_q        = q.wa;
  assign wr_data_q        = q.wv;
  assign three_wire_q     = q.three;
  assign write_auto_increment_q        = q.regs[scp_pkg::REG_CIF][scp_pkg::WRITE_AUTO_INCREMENT_BIT];

endmodule : scp_dev

// File: logic/scp_pkg.sv
// ----------------------------------------------------------------
// shared constants of the serial control port
// ----------------------------------------------------------------
package scp_pkg;
  // register word layout
  localparam int          REG_W         = 16;
  localparam int          ADDR_W        = 7;
  localparam int          WORD_W        = 24;
  localparam int          WORD_RW_BIT   = 23;
  localparam int          WORD_ADDR_MSB = 22;
  localparam int          WORD_ADDR_LSB = 16;
  localparam int          WORD_BITS     = 24;
  localparam int          RD_HDR_BITS   = 8;
  // register offsets and fields
  localparam logic [6:0]  REG_SOFT_RESET = 7'h00;
  localparam logic [6:0]  REG_REVISION   = 7'h01;
  localparam logic [6:0]  REG_GPIO       = 7'h08;
  localparam logic [6:0]  REG_CIF        = 7'h09;
  localparam int          MODE_GPIO_BIT  = 7;
  localparam int          WRITE_AUTO_INCREMENT_BIT    = 1;
  localparam logic [15:0] REG_CIF_RESET  = 16'h0002;
  // 2-wire bus address
  localparam logic [6:0]  DEV_BUS_ADDR   = 7'h1A;
  localparam int          TW_FRAME_BITS  = 36;
  // pin indices in the device synchroniser
  localparam int          PIN_SCLK = 0;
  localparam int          PIN_SD   = 1;
  localparam int          PIN_CS   = 2;
  localparam int          PIN_MODE = 3;
  // host register map
  localparam logic [11:0] HOST_WORD_OFS = 12'h000;
  localparam logic [11:0] HOST_CTRL_OFS = 12'h004;
  localparam logic [11:0] HOST_STAT_OFS = 12'h008;
  localparam int          CTRL_GO_BIT   = 0;
  localparam int          CTRL_READ_BIT = 1;
  localparam int          CTRL_TW_BIT   = 2;
  localparam int          STAT_BUSY_BIT = 0;
  localparam int          STAT_NACK_BIT = 1;
  localparam int          STAT_RD_LSB   = 16;
  // timing
  localparam int          CLK_PERIOD_NS  = 5;
  localparam int          SCLK_PERIOD_NS = 160;
  localparam int          SCLK_HALF_CYC  =
    (SCLK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
endpackage : scp_pkg

// File: logic/scp_link_if.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// link between host and codec control port
// ----------------------------------------------------------------
interface scp_link_if;
  logic serial_clock;
  logic chip_select_line;
  logic interface_select;
  logic host_sd_o;
  logic host_sd_oe_n;
  logic dev_sd_o;
  logic dev_sd_oe_n;
  logic serial_data_line;

  // wired data line with pull-up, a released end reads high
  assign serial_data_line = (host_sd_oe_n | host_sd_o)
                          & (dev_sd_oe_n | dev_sd_o);

  modport device (
    input  serial_clock,
    input  chip_select_line,
    input  interface_select,
    input  serial_data_line,
    output dev_sd_o,
    output dev_sd_oe_n
  );
  modport host (
    output serial_clock,
    output chip_select_line,
    output interface_select,
    input  serial_data_line,
    output host_sd_o,
    output host_sd_oe_n
  );
endinterface : scp_link_if

// File: logic/scp_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// serial control port, host end with apb registers
// ----------------------------------------------------------------
module scp_host #(
  parameter int HALF = scp_pkg::SCLK_HALF_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output wire logic [31:0] prdata,
  output wire logic        pready,
  output wire logic        pslverr,
  scp_link_if.host         link
);

  typedef enum logic [2:0] {
    H_IDLE, H_START, H_LO, H_HI, H_END1, H_END2, H_END3
  } scp_h_e;
  typedef struct packed {
    logic [2:0]  s;
    logic        f;
    scp_h_e      st;
    logic [7:0]  tmr;
    logic [5:0]  n;
    logic [35:0] tx;
    logic [35:0] rel;
    logic [15:0] rx;
    logic [23:0] word;
    logic        rd;
    logic        two;
    logic        busy;
    logic        nack;
    logic [15:0] rdata;
    logic        scl;
    logic        cs;
    logic        sd_o;
    logic        sd_oe_n;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } scp_host_st_s;

  localparam logic [7:0] T_FULL = 8'(HALF - 1);
  localparam logic [7:0] T_MID  = 8'(HALF / 2);

  scp_host_st_s q;
  scp_host_st_s d;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic setup;
    logic acc;
    logic hit;
    setup = psel & ~penable;
    acc   = psel & penable & q.pready & pwrite & ~q.pslverr;
    hit   = paddr == scp_pkg::HOST_WORD_OFS
          || paddr == scp_pkg::HOST_CTRL_OFS
          || paddr == scp_pkg::HOST_STAT_OFS;
    d = q;
    // data line sync, level taken once stages two and three agree
    d.s = {q.s[1:0], link.serial_data_line};
    d.f = (q.s[1] & q.s[2]) | (q.f & (q.s[1] ^ q.s[2]));
    // apb slave: answer in the cycle after setup
    d.pready  = setup;
    d.pslverr = setup & ~hit;
    if (setup) begin
      d.prdata = 32'h0000_0000;
      if (paddr == scp_pkg::HOST_WORD_OFS) begin
        d.prdata = {8'h00, q.word};
      end else if (paddr == scp_pkg::HOST_CTRL_OFS) begin
        d.prdata[scp_pkg::CTRL_READ_BIT] = q.rd;
        d.prdata[scp_pkg::CTRL_TW_BIT]   = q.two;
      end else if (paddr == scp_pkg::HOST_STAT_OFS) begin
        d.prdata[scp_pkg::STAT_BUSY_BIT] = q.busy;
        d.prdata[scp_pkg::STAT_NACK_BIT] = q.nack;
        d.prdata[31:scp_pkg::STAT_RD_LSB] = q.rdata;
      end
    end
    if (acc && !q.busy) begin
      if (paddr == scp_pkg::HOST_WORD_OFS) begin
        d.word = pwdata[23:0];
      end else if (paddr == scp_pkg::HOST_CTRL_OFS) begin
        d.rd  = pwdata[scp_pkg::CTRL_READ_BIT];
        d.two = pwdata[scp_pkg::CTRL_TW_BIT];
        if (pwdata[scp_pkg::CTRL_GO_BIT]) begin
          d.busy = 1'b1;
          d.st   = H_START;
          d.tmr  = T_FULL;
          d.rx   = 16'h0000;
          if (pwdata[scp_pkg::CTRL_TW_BIT]) begin
            // address, register, high, low bytes, each then an ack slot
            d.tx  = {scp_pkg::DEV_BUS_ADDR, 1'b0, 1'b1, q.word[23:16],
                     1'b1, q.word[15:8], 1'b1, q.word[7:0], 1'b1};
            d.rel = {8'h00, 1'b1, 8'h00, 1'b1, 8'h00, 1'b1, 8'h00, 1'b1};
            d.n   = 6'(scp_pkg::TW_FRAME_BITS);
          end else begin
            d.tx  = {pwdata[scp_pkg::CTRL_READ_BIT], q.word[22:0],
                     12'h000};
            d.rel = {8'h00, {16{pwdata[scp_pkg::CTRL_READ_BIT]}},
                     12'h000};
            d.n   = 6'(scp_pkg::WORD_BITS);
          end
        end
      end
    end
    if (q.tmr != 8'h00) begin
      d.tmr = q.tmr - 8'h01;
    end
    unique case (q.st)
      H_IDLE: ;
      H_START: begin
        if (q.two) begin
          d.sd_oe_n = 1'b0;
          d.sd_o    = 1'b0;
        end else begin
          d.cs = 1'b0;
        end
        if (q.tmr == 8'h00) begin
          d.st  = H_LO;
          d.scl = 1'b0;
          d.tmr = T_FULL;
        end
      end
      H_LO: begin
        // data moves mid-low so it never changes with the clock high
        if (q.tmr == T_MID) begin
          d.sd_o    = q.tx[35];
          d.sd_oe_n = q.rel[35] | (q.two & q.tx[35]);
        end
        if (q.tmr == 8'h00) begin
          d.st  = H_HI;
          d.scl = 1'b1;
          d.tmr = T_FULL;
        end
      end
      H_HI: begin
        if (q.tmr == 8'h00) begin
          if (q.rel[35]) begin
            d.rx = {q.rx[14:0], q.f};
          end
          d.tx  = {q.tx[34:0], 1'b0};
          d.rel = {q.rel[34:0], 1'b0};
          d.n   = q.n - 6'h01;
          d.st  = (q.n == 6'h01) ? H_END1 : H_LO;
          d.scl = 1'b0;
          d.tmr = T_FULL;
        end
      end
      H_END1: begin
        if (q.tmr == T_MID) begin
          d.sd_oe_n = ~q.two;
          d.sd_o    = 1'b0;
        end
        if (q.tmr == 8'h00) begin
          d.st  = H_END2;
          d.scl = q.two;
          d.tmr = T_FULL;
        end
      end
      H_END2: begin
        if (q.tmr == 8'h00) begin
          d.st      = H_END3;
          d.sd_oe_n = 1'b1;
          d.cs      = 1'b1;
          d.tmr     = T_FULL;
        end
      end
      H_END3: begin
        if (q.tmr == 8'h00) begin
          d.st    = H_IDLE;
          d.busy  = 1'b0;
          d.nack  = q.two & (|q.rx[3:0]);
          d.rdata = q.rx;
          d.scl   = 1'b1;
        end
      end
      default: d.st = H_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q         <= '0;
      q.s       <= '1;
      q.f       <= 1'b1;
      q.scl     <= 1'b1;
      q.cs      <= 1'b1;
      q.sd_o    <= 1'b1;
      q.sd_oe_n <= 1'b1;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // outputs straight from state; mode pin low only for 2-wire
  assign link.serial_clock     = q.scl;
  assign link.chip_select_line = q.cs;
  assign link.interface_select = ~q.two;
  assign link.host_sd_o        = q.sd_o;
  assign link.host_sd_oe_n     = q.sd_oe_n;
  assign prdata                = q.prdata;
  assign pready                = q.pready;
  assign pslverr               = q.pslverr;

endmodule : scp_host

// File: sim/scp_link_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// link checker between host end and device end
// ----------------------------------------------------------------
module scp_link_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic serial_clock,
  input wire logic chip_select_line,
  input wire logic interface_select,
  input wire logic host_sd_o,
  input wire logic host_sd_oe_n,
  input wire logic dev_sd_o,
  input wire logic dev_sd_oe_n,
  input wire logic serial_data_line
);
  logic       scl_q;
  logic       sdl_q;
  logic       cs_q;
  logic [5:0] cnt_q;
  logic       tw;
  logic       rise;
  logic       start;
  logic       stop;

  // edge and bus condition decode
  assign tw    = ~interface_select;
  assign rise  = serial_clock & ~scl_q;
  assign start = tw & serial_clock & scl_q & sdl_q & ~serial_data_line;
  assign stop  = tw & serial_clock & scl_q & ~sdl_q & serial_data_line;

  // count clock rises since the frame began
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'h1;
      sdl_q <= 1'h1;
      cs_q  <= 1'h1;
      cnt_q <= 6'h00;
    end else begin
      scl_q <= serial_clock;
      sdl_q <= serial_data_line;
      cs_q  <= chip_select_line;
      if (start || (cs_q && !chip_select_line)) begin
        cnt_q <= 6'h00;
      end else if (rise && (tw || !chip_select_line)) begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  cs_idle_tw_a: assert property (tw |-> chip_select_line)
    else $error("select active in 2-wire mode");
  sclk_high_a: assert property ($rose(serial_clock) |-> serial_clock[*8])
    else $error("serial clock high phase too short");
  host_setup_a: assert property (interface_select && !chip_select_line
    && !$past(chip_select_line) && !host_sd_oe_n && $changed(host_sd_o)
    |-> !serial_clock) else $error("host data moved while clock high");
  ack_slot_a: assert property (tw && $fell(dev_sd_oe_n)
    |-> cnt_q inside {6'h08, 6'h11, 6'h1A, 6'h23})
    else $error("acknowledge outside its slot");
  ack_low_a: assert property (tw && !dev_sd_oe_n |-> !dev_sd_o)
    else $error("device drives high on 2-wire bus");
  ack_release_a: assert property (tw && $fell(dev_sd_oe_n)
    |-> ##[8:40] dev_sd_oe_n) else $error("acknowledge not released");
  rd_start_a: assert property (interface_select && $fell(dev_sd_oe_n)
    |-> !chip_select_line && cnt_q == 6'h08)
    else $error("readback drive at wrong bit");
  rd_release_a: assert property ($rose(chip_select_line)
    |-> ##[0:8] dev_sd_oe_n) else $error("data line held after frame");
  word_len_a: assert property (interface_select && $rose(chip_select_line)
    |-> cnt_q == 6'h18) else $error("3-wire frame not 24 bits");
  tw_len_a: assert property (stop |-> cnt_q == 6'h25)
    else $error("2-wire frame length wrong at stop");
endmodule : scp_link_monitor

// File: sim/tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// testbench: apb host end driving the device end
// ----------------------------------------------------------------
module tb;
  localparam logic [15:0] ID  = 16'hC3A5; // arbitrary value
  localparam logic [2:0]  REV = 3'h5;     // arbitrary value
  logic        pclk;
  logic        presetn;
  logic        run;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wr_pulse_q;
  logic [6:0]  wr_addr_q;
  logic [15:0] wr_data_q;
  logic        three_wire_q;
  logic        write_auto_increment_q;
  int          miscompares;
  int          compares;
  int          pulses;
  logic [31:0] st;
  logic        err;
  logic [6:0]  ra [3] = '{7'h05, 7'h00, 7'h01};
  logic [15:0] rv [3] = '{16'hA5C3, ID, {13'h0000, REV}};

  scp_link_if link ();

  scp_host #(.HALF(8)) scp_host_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(run), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.host));

  scp_dev #(.REG_COUNT(16), .PART_ID(ID), .REVISION(REV)) scp_dev_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(run), .link(link.device),
    .wr_pulse_q(wr_pulse_q), .wr_addr_q(wr_addr_q), .wr_data_q(wr_data_q),
    .three_wire_q(three_wire_q), .write_auto_increment_q(write_auto_increment_q));

  scp_link_monitor scp_link_monitor_inst (
    .pclk(pclk), .presetn(presetn), .serial_clock(link.serial_clock),
    .chip_select_line(link.chip_select_line),
    .interface_select(link.interface_select), .host_sd_o(link.host_sd_o),
    .host_sd_oe_n(link.host_sd_oe_n), .dev_sd_o(link.dev_sd_o),
    .dev_sd_oe_n(link.dev_sd_oe_n),
    .serial_data_line(link.serial_data_line));

  // clock and device write counter
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (wr_pulse_q === 1'h1) begin
      pulses++;
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    psel    <= 1'h1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    // only the watchdog ends a wait for the answer
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    q   = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  // load a control word, start it, poll until idle
  task automatic xfer(input logic [23:0] w, input logic [2:0] c);
    logic [31:0] q;
    apb(1'h1, scp_pkg::HOST_WORD_OFS, {8'h00, w}, q);
    apb(1'h1, scp_pkg::HOST_CTRL_OFS, {29'h00000000, c}, q);
    do begin
      apb(1'h0, scp_pkg::HOST_STAT_OFS, 32'h00000000, st);
    end while (st[scp_pkg::STAT_BUSY_BIT] !== 1'h0);
    repeat (10) @(posedge pclk); // device commit follows select rise
  endtask : xfer

  task automatic tally_and_finish();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 0; presetn = 0; run = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = '0; pwdata = '0; miscompares = 0; compares = 0; pulses = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    repeat (8) @(posedge pclk);
    check(three_wire_q, 1'h1);
    check(write_auto_increment_q, 1'h1);
    apb(1'h0, scp_pkg::HOST_STAT_OFS, 32'h00000000, st);
    check(st, 32'h00000000);
    apb(1'h0, 12'h00C, 32'h00000000, st);
    check(err, 1'h1);
    $display("test reset done");
    xfer({1'h0, 7'h05, 16'hA5C3}, 3'h1);
    check(pulses, 1);
    check({wr_addr_q, wr_data_q}, {7'h05, 16'hA5C3});
    for (int i = 0; i < 3; i++) begin
      xfer({1'h1, ra[i], 16'h0000}, 3'h3);
      check(st[31:16], rv[i]);
    end
    $display("test three wire done");
    xfer({8'h86, 16'h3C96}, 3'h5);
    check(st[scp_pkg::STAT_NACK_BIT], 1'h0);
    check({wr_addr_q, wr_data_q}, {7'h06, 16'h3C96});
    check(three_wire_q, 1'h0);
    xfer({1'h1, 7'h06, 16'h0000}, 3'h3);
    check(st[31:16], 16'h3C96);
    check(three_wire_q, 1'h1);
    $display("test two wire done");
    xfer({1'h0, scp_pkg::REG_CIF, 16'h0000}, 3'h1);
    check(write_auto_increment_q, 1'h0);
    xfer({8'h87, 16'h5AA5}, 3'h5);
    check(st[scp_pkg::STAT_NACK_BIT], 1'h0);
    check({wr_addr_q, wr_data_q}, {7'h07, 16'h5AA5});
    xfer({1'h0, scp_pkg::REG_SOFT_RESET, 16'hFFFF}, 3'h1);
    check(write_auto_increment_q, 1'h1);
    xfer({1'h1, 7'h05, 16'h0000}, 3'h3);
    check(st[31:16], 16'h0000);
    $display("test soft reset done");
    xfer({1'h0, scp_pkg::REG_GPIO, 16'h0080}, 3'h1);
    xfer({8'h07, 16'h1234}, 3'h5);
    check(three_wire_q, 1'h1);
    check(st[scp_pkg::STAT_NACK_BIT], 1'h1);
    check({wr_addr_q, wr_data_q}, {7'h08, 16'h0080});
    $display("test mode force done");
    xfer({1'h0, scp_pkg::REG_CIF, 16'h0000}, 3'h1);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    repeat (8) @(posedge pclk);
    check(write_auto_increment_q, 1'h1);
    xfer({1'h1, scp_pkg::REG_GPIO, 16'h0000}, 3'h3);
    check(st[31:16], 16'h0000);
    check(pulses, 7);
    $display("test power reset done");
    tally_and_finish();
  end

  // watchdog against a hung transfer
  initial begin
    #300000;
    miscompares++;
    tally_and_finish();
  end
endmodule : tb
